// file: hdl/bgp_map.vh
// Register offsets, field positions, reset values and command codes for the bank port
`ifndef BGP_MAP_VH
`define BGP_MAP_VH
`define BGP_ADDR_W 4
`define BGP_OFS_DIR 4'h0
`define BGP_OFS_OUT 4'h1
`define BGP_OFS_IN 4'h2
`define BGP_OFS_BANK 4'h3
`define BGP_OFS_CMD 4'h4
`define BGP_OFS_STAT 4'h5
`define BGP_DIR_RST 16'h0000
`define BGP_OUT_RST 16'h0000
`define BGP_BANK_MAIN 1'b0
`define BGP_BANK_AUX 1'b1
`define BGP_CMD_INPUT 3'h0
`define BGP_CMD_OUTPUT 3'h1
`define BGP_CMD_MAIN 3'h2
`define BGP_CMD_AUX 3'h3
`define BGP_CMD_SAMPLE 3'h4
`define BGP_CMD_OP_LSB 8
`define BGP_CMD_OP_MSB 10
`define BGP_CMD_PIN_MSB 3
`endif

// file: hdl/bgp_sync.v
// Input synchroniser for the sensed pin levels
`timescale 1ns/10ps
module bgp_sync #(
  parameter W = 16
) (
  input wire mclk,
  input wire arst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;

  // Two flops; first stage read only by the second
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // bgp_sync

// file: hdl/bgp_bank.v
// One bank of direction bits and output latches
`timescale 1ns/10ps
`include "bgp_map.vh"
module bgp_bank #(
  parameter W = 16
) (
  input wire mclk,
  input wire arst_n,
  input wire sel,
  input wire dir_we,
  input wire out_we,
  input wire [W-1:0] wdata,
  input wire [W-1:0] set_in,
  input wire [W-1:0] set_out,
  output reg [W-1:0] dir_q,
  output reg [W-1:0] out_q
);
  // Full-width reset words, cut to the bank width on purpose
  localparam [15:0] DIR_RST = `BGP_DIR_RST;
  localparam [15:0] OUT_RST = `BGP_OUT_RST;

  // Writes land only when this bank is selected
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dir_q <= DIR_RST[W-1:0];
      out_q <= OUT_RST[W-1:0];
    end else if (sel) begin
      if (dir_we)
        dir_q <= wdata;
      else
        dir_q <= (dir_q | set_out) & ~set_in;
      if (out_we)
        out_q <= wdata;
    end
  end
endmodule // bgp_bank

// file: hdl/bgp_port.v
// Banked general-purpose pin port with per-pin direction
// How it works
// - After reset every pin of both banks is an input.
// - Writing 0 to a direction bit makes that pin an input.
// - Input state register returns the level sensed on the pin.
// - Latch writes on input pins are stored but not driven.
// - Turning a pin to output drives the last latched value at once.
// - Pin indices span 0 to 15, or 0 to 7 on the small variant.
// - Sampling operations force their pin to input first.
// - Bank select value 0 picks main bank, 1 picks auxiliary.
// - Auxiliary bank adds 16 pins; one bank reachable at a time.
// - Chosen bank stays until another select or reset.
// - Banks keep independent state; one never disturbs the other.
// - Select accepted always; auxiliary pins exist only when enabled.
// - Dedicated commands select main or auxiliary bank directly.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "bgp_map.vh"
module bgp_port #(
  parameter NPIN = 16,
  parameter HAS_AUX = 1
) (
  input wire mclk,
  input wire arst_n,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  input wire [NPIN-1:0] main_pin_i,
  output reg [NPIN-1:0] main_pin_o,
  output reg [NPIN-1:0] main_pin_oe,
  input wire [NPIN-1:0] aux_pin_i,
  output reg [NPIN-1:0] aux_pin_o,
  output reg [NPIN-1:0] aux_pin_oe
);
  reg bank_q;
  wire [NPIN-1:0] main_dir;
  wire [NPIN-1:0] main_out;
  wire [NPIN-1:0] aux_dir;
  wire [NPIN-1:0] aux_out;
  wire [NPIN-1:0] main_in;
  wire [NPIN-1:0] aux_in;
  wire [NPIN-1:0] wd = wdata[NPIN-1:0];
  wire [2:0] op = wdata[`BGP_CMD_OP_MSB:`BGP_CMD_OP_LSB];
  wire [3:0] pin = wdata[`BGP_CMD_PIN_MSB:0];
  wire cmd_we = wr && (addr == `BGP_OFS_CMD);
  wire pin_ok = ({28'h0, pin} < NPIN);
  reg [NPIN-1:0] set_in;
  reg [NPIN-1:0] set_out;
  reg [NPIN-1:0] one_hot;
  reg [15:0] rd_dir;
  reg [15:0] rd_out;
  reg [15:0] rd_in;
  integer i;

  // Zero-extend the selected bank to the bus; a zero-width pad is
  // illegal, so the upper bits are cleared first instead
  always @* begin
    rd_dir = 16'h0000;
    rd_out = 16'h0000;
    rd_in = 16'h0000;
    rd_dir[NPIN-1:0] = bank_q ? aux_dir : main_dir;
    rd_out[NPIN-1:0] = bank_q ? aux_out : main_out;
    rd_in[NPIN-1:0] = bank_q ? aux_in : main_in;
  end

  // Per-pin command decode; out of range indices are ignored
  always @* begin
    one_hot = {NPIN{1'b0}};
    for (i = 0; i < NPIN; i = i + 1)
      one_hot[i] = pin_ok && (pin == i[3:0]);
    set_in = {NPIN{1'b0}};
    set_out = {NPIN{1'b0}};
    if (cmd_we && (op == `BGP_CMD_INPUT || op == `BGP_CMD_SAMPLE))
      set_in = one_hot;
    if (cmd_we && op == `BGP_CMD_OUTPUT)
      set_out = one_hot;
  end

  // Bank select register, kept until next select or reset
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bank_q <= `BGP_BANK_MAIN;
    end else if (wr && addr == `BGP_OFS_BANK) begin
      bank_q <= wdata[0];
    end else if (cmd_we && op == `BGP_CMD_MAIN) begin
      bank_q <= `BGP_BANK_MAIN;
    end else if (cmd_we && op == `BGP_CMD_AUX) begin
      bank_q <= `BGP_BANK_AUX;
    end
  end

  bgp_bank #(.W(NPIN)) u_main (
    .mclk(mclk),
    .arst_n(arst_n),
    .sel(bank_q == `BGP_BANK_MAIN),
    .dir_we(wr && addr == `BGP_OFS_DIR),
    .out_we(wr && addr == `BGP_OFS_OUT),
    .wdata(wd),
    .set_in(set_in),
    .set_out(set_out),
    .dir_q(main_dir),
    .out_q(main_out)
  );

  bgp_bank #(.W(NPIN)) u_aux (
    .mclk(mclk),
    .arst_n(arst_n),
    .sel(bank_q == `BGP_BANK_AUX),
    .dir_we(wr && addr == `BGP_OFS_DIR),
    .out_we(wr && addr == `BGP_OFS_OUT),
    .wdata(wd),
    .set_in(set_in),
    .set_out(set_out),
    .dir_q(aux_dir),
    .out_q(aux_out)
  );

  bgp_sync #(.W(NPIN)) u_sync_main (
    .mclk(mclk),
    .arst_n(arst_n),
    .d(main_pin_i),
    .q(main_in)
  );

  bgp_sync #(.W(NPIN)) u_sync_aux (
    .mclk(mclk),
    .arst_n(arst_n),
    .d(aux_pin_i),
    .q(aux_in)
  );

  // Pin drivers registered; aux bank silent when not fitted
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      main_pin_o <= {NPIN{1'b0}};
      main_pin_oe <= {NPIN{1'b0}};
      aux_pin_o <= {NPIN{1'b0}};
      aux_pin_oe <= {NPIN{1'b0}};
    end else begin
      main_pin_o <= main_out & main_dir;
      main_pin_oe <= main_dir;
      aux_pin_o <= (HAS_AUX != 0) ? (aux_out & aux_dir) : {NPIN{1'b0}};
      aux_pin_oe <= (HAS_AUX != 0) ? aux_dir : {NPIN{1'b0}};
    end
  end

  // Read mux for the selected bank; unmapped reads give zero
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `BGP_OFS_DIR:
          rdata <= rd_dir;
        `BGP_OFS_OUT:
          rdata <= rd_out;
        `BGP_OFS_IN:
          rdata <= rd_in;
        `BGP_OFS_BANK:
          rdata <= {15'h0000, bank_q};
        default:
          rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule // bgp_port

// file: tb/bgp_pins.sv
// External circuitry model seen by one bank of pins
`timescale 1ns/10ps
module bgp_pins #(
  parameter W = 16
) (
  input wire [W-1:0] oe,
  input wire [W-1:0] o,
  input wire [W-1:0] ext,
  output wire [W-1:0] pin
);
  // Outside level wins wherever the port lets go of a pin
  assign pin = (oe & o) | (~oe & ext);
endmodule // bgp_pins

// file: tb/bgp_port_assertions.sv
// Port-level checker for the banked pin port
`timescale 1ns/10ps
module bgp_port_chk #(
  parameter NPIN = 16,
  parameter HAS_AUX = 1
) (
  input wire mclk,
  input wire arst_n,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  input wire [NPIN-1:0] main_pin_o,
  input wire [NPIN-1:0] main_pin_oe,
  input wire [NPIN-1:0] aux_pin_o,
  input wire [NPIN-1:0] aux_pin_oe
);
  reg aux_sel_q;

  // Shadow of the bank in effect; a direction write is held against
  // the bank it landed in, and an absent bank must stay silent
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aux_sel_q <= 1'b0;
    end else if (wr && addr == 4'h3) begin
      aux_sel_q <= wdata[0];
    end else if (wr && addr == 4'h4 && wdata[10:8] == 3'h2) begin
      aux_sel_q <= 1'b0;
    end else if (wr && addr == 4'h4 && wdata[10:8] == 3'h3) begin
      aux_sel_q <= 1'b1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  rst_quiet_a: assert property (
    $rose(arst_n) |-> !(main_pin_oe | aux_pin_oe))
    else $error("pins driven after reset");
  dir_set_a: assert property (
    wr && addr == 4'h0 |-> ##2 ($past(aux_sel_q, 2)
    ? aux_pin_oe == ((HAS_AUX != 0) ? $past(wdata[NPIN-1:0], 2)
                                    : {NPIN{1'b0}})
    : main_pin_oe == $past(wdata[NPIN-1:0], 2)))
    else $error("direction write not applied");
  out_mask_a: assert property (
    !((main_pin_o & ~main_pin_oe) | (aux_pin_o & ~aux_pin_oe)))
    else $error("undriven pin shows value");
  main_lag_a: assert property (
    $changed(main_pin_oe) |-> $past(wr, 2))
    else $error("main pins moved without a write");
  aux_lag_a: assert property (
    $changed(aux_pin_oe) |-> $past(wr, 2))
    else $error("aux pins moved without a write");
  aux_absent_a: assert property (
    HAS_AUX == 0 |-> aux_pin_oe == 0)
    else $error("absent bank drives");
  rd_idle_a: assert property (
    !$past(rd) |-> rdata == 16'h0)
    else $error("read data outside its slot");
  unmapped_a: assert property (
    rd && addr >= 4'h5 |=> rdata == 16'h0)
    else $error("unmapped read not zero");
  cover property (wr && addr == 4'h4);
  cover property (wr && addr == 4'h3 && wdata[0]);
  cover property (rd && addr == 4'h2);
endmodule // bgp_port_chk

// file: tb/testbench.sv
// Self-checking bench for the banked pin port
`timescale 1ns/10ps
module testbench;
  reg mclk = 0, arst_n = 0, wr = 0, rd = 0;
  reg [3:0] addr = 4'h0;
  reg [15:0] wdata = 16'h0, ext_m = 16'h3c3c, ext_x = 16'hffff;
  wire [15:0] rdata, m_i, m_o, m_oe, x_i, x_o, x_oe;
  wire [15:0] s_rdata;
  wire [7:0] s_m_i, s_m_o, s_m_oe, s_x_o, s_x_oe;
  integer n_fail = 0, num_checks = 0, k;
  reg [63:0] rows [0:10];
  always #2.5 mclk = ~mclk;
  bgp_port u_bgp_port (.mclk(mclk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .main_pin_i(m_i),
    .main_pin_o(m_o), .main_pin_oe(m_oe), .aux_pin_i(x_i),
    .aux_pin_o(x_o), .aux_pin_oe(x_oe));
  bgp_pins u_bgp_pins (.oe(m_oe), .o(m_o), .ext(ext_m), .pin(m_i));
  bgp_pins u_bgp_pins_x (.oe(x_oe), .o(x_o), .ext(ext_x), .pin(x_i));
  // Small variant without auxiliary pins, sharing the same bus
  bgp_port #(.NPIN(8), .HAS_AUX(0)) u_bgp_port_small (.mclk(mclk),
    .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(s_rdata), .main_pin_i(s_m_i), .main_pin_o(s_m_o),
    .main_pin_oe(s_m_oe), .aux_pin_i(ext_x[7:0]), .aux_pin_o(s_x_o),
    .aux_pin_oe(s_x_oe));
  bgp_pins #(.W(8)) u_bgp_pins_s (.oe(s_m_oe), .o(s_m_o),
    .ext(ext_m[7:0]), .pin(s_m_i));
  task chk(input [15:0] seen, input [15:0] exp, input [63:0] nm);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD %0s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wr_t(input [3:0] a, input [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task rd_t(input [3:0] a, input [15:0] e, input [15:0] es);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, e, "rdata");
    chk(s_rdata, es, "s_rdata");
  endtask
  // Rows: address, data, then main enables and drive after the write
  initial begin
    rows[0] = 64'h0001_00a5_0000_0000;
    rows[1] = 64'h0000_00ff_00ff_00a5;
    rows[2] = 64'h0000_000f_000f_0005;
    rows[3] = 64'h0004_0108_010f_0005;
    rows[4] = 64'h0004_0408_000f_0005;
    rows[5] = 64'h0004_0003_0007_0005;
    rows[6] = 64'h0004_0701_0007_0005;
    rows[7] = 64'h0003_0001_0007_0005;
    rows[8] = 64'h0000_ffff_0007_0005;
    rows[9] = 64'h0004_0200_0007_0005;
    rows[10] = 64'h0000_0000_0000_0000;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    rd_t(4'h0, 16'h0, 16'h0);
    for (k = 0; k < 11; k = k + 1) begin
      wr_t(rows[k][51:48], rows[k][47:32]);
      repeat (2) @(posedge mclk);
      #1 chk(m_oe, rows[k][31:16], "oe");
      chk(m_o, rows[k][15:0], "o");
      chk({8'h0, s_m_oe}, rows[k][31:16] & 16'h00ff, "s_oe");
    end
    chk(x_oe, 16'hffff, "aux_oe");
    chk({8'h0, s_x_oe}, 16'h0, "s_aux_oe");
    rd_t(4'h2, 16'h3c3c, 16'h003c);
    rd_t(4'h9, 16'h0, 16'h0);
    // Direct select, then one idle cycle later a latch write to the aux bank
    wr_t(4'h4, 16'h0300);
    wr_t(4'h1, 16'h00f0);
    repeat (4) @(posedge mclk);
    #1 chk(x_o, 16'h00f0, "aux_o");
    chk({8'h0, s_x_o}, 16'h0, "s_aux_o");
    rd_t(4'h2, 16'h00f0, 16'h00ff);
    arst_n <= 1'b0;
    #1 chk(m_oe | x_oe, 16'h0, "rst_oe");
    @(posedge mclk);
    arst_n <= 1'b1;
    rd_t(4'h3, 16'h0, 16'h0);
    close_out;
  end
  // Watchdog well beyond the roughly 70 cycles the run needs
  initial begin
    #5000;
    n_fail = n_fail + 1;
    close_out;
  end
endmodule // testbench
bind bgp_port bgp_port_chk #(.NPIN(NPIN), .HAS_AUX(HAS_AUX)) u_bgp_port_chk (
  .mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .main_pin_o(main_pin_o),
  .main_pin_oe(main_pin_oe), .aux_pin_o(aux_pin_o), .aux_pin_oe(aux_pin_oe));
